// >>> ohpc_top.sv
// Overheat pin control: pin input timing, fan full_speed_on_alarm, pin output and speed input mapping.
//
// Contract
// [R1] The monitoring of the overheat pin as an input works only while config_3 bit 1 is one.
// [R2] With config_3 bit 2 set, every fan drive runs at full duty while the pin is asserted; the code also needs bit 1 set and forces only running fans.
// [R3] With config_3 bit 2 clear, every fan keeps its programmed duty whatever the pin does.
// [R4] Bit 5 of alert_mask_2 blocks the alert output for the overheat limit condition.
// [R5] A limit of zero flags the limit and alerts on the very first assertion.
// [R6] A nonzero limit alerts only once the cumulative assertion time passes the limit.
// [R7] An enabled channel whose temperature exceeds its critical limit by a quarter degree pulls the pin low.
// [R8] The output is re-evaluated each monitoring cycle and released at or below the limit.
// [R9] Once asserted the pin stays low for at least one whole monitoring cycle.
// [R10] Remote 1, local and remote 2 compare against critical limits at 0x6A, 0x6B and 0x6C.
// [R11] Bit 3 of 0x5F, 0x60 and 0x61 enables the output per channel, and any enabled trip asserts.
// [R12] By default speed input 1 follows drive 1, input 2 drive 2, and inputs 3 and 4 drive 3.
// [R13] With bit 4 of 0x62 set, speed inputs 2, 3 and 4 follow drive 2.
// [R14] Full-speed full_speed_on_alarm acts only on a fan that is already running.
// [R15] The limit flag, bit 5 of status 2, sets whenever the timer value exceeds the limit.
// [R16] Masking blocks only the alert output; the status flag still sets.
// [R17] The pin is open drain: it is only pulled low or released and is synchronised before use.
`timescale 1ns/1ns
module ohpc_top
	import ohpc_pkg::*;
#(
	parameter int UNIT_CYCLES = TIMER_UNIT_CYCLES,
	parameter int CHANNELS    = 3
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic  [7:0] reg_addr,
	input  wire logic  [7:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic       [7:0] reg_rdata,
	input  wire logic        overheat_line_in,
	output logic             overheat_line_out,
	output logic             overheat_line_oe,
	output logic             smbalert_n,
	input  wire logic  [9:0] temp_remote1,
	input  wire logic  [9:0] temp_local,
	input  wire logic  [9:0] temp_remote2,
	input  wire logic  [2:0] temp_valid,
	input  wire logic        monitor_cycle_done,
	input  wire logic  [7:0] duty_1,
	input  wire logic  [7:0] duty_2,
	input  wire logic  [7:0] duty_3,
	input  wire logic  [2:0] fan_running,
	output logic       [7:0] fan_drive_1,
	output logic       [7:0] fan_drive_2,
	output logic       [7:0] fan_drive_3,
	input  wire logic  [2:0] drive_pwm,
	output logic       [3:0] speed_input_gate
);

	////////////////////////////////////////////////////////////////////////////////
	logic [7:0] temp_config_reg [CHANNELS];
	logic [7:0] critical_limit_reg [CHANNELS];
	logic [7:0] acoustics_control_1_reg;
	logic [7:0] alert_mask_2_reg;
	logic [7:0] config_3_reg;
	logic [7:0] overheat_limit_reg;
	logic       overheat_limit_flag_reg;
	logic [7:0] reg_rdata_reg;
	logic       line_meta_reg;
	logic       line_sync_reg;
	logic       drive_low_reg;
	logic [1:0] drive_low_hist_reg;
	logic       smbalert_n_reg;
	logic [2:0] trip_reg;
	logic [7:0] fan_drive_reg [CHANNELS];
	logic [3:0] speed_gate_reg;
	logic [9:0] temp_in [CHANNELS];
	logic [7:0] duty_in [CHANNELS];
	logic [7:0] timer_value;
	logic       line_asserted;
	logic       timer_run;
	logic       timer_clear;
	logic       status_clear;
	logic       limit_hit;
	logic       full_speed_on_alarm_active;
	logic [2:0] out_enable;

	assign temp_in[0] = temp_remote1;
	assign temp_in[1] = temp_local;
	assign temp_in[2] = temp_remote2;
	assign duty_in[0] = duty_1;
	assign duty_in[1] = duty_2;
	assign duty_in[2] = duty_3;

	////////////////////////////////////////////////////////////////////////////////
	// Register writes.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acoustics_control_1_reg <= RST_ACOUSTICS;
			alert_mask_2_reg        <= RST_ALERT_MASK_2;
			config_3_reg            <= RST_CONFIG_3;
			overheat_limit_reg      <= RST_OVERHEAT_LIMIT;
		end else if (reg_wr) begin
			if (reg_addr == OFS_ACOUSTICS_CONTROL_1) begin
				acoustics_control_1_reg <= reg_wdata;
			end
			if (reg_addr == OFS_ALERT_MASK_2) begin
				alert_mask_2_reg <= reg_wdata;
			end
			if (reg_addr == OFS_CONFIG_3) begin
				config_3_reg <= reg_wdata;
			end
			if (reg_addr == OFS_OVERHEAT_LIMIT) begin
				overheat_limit_reg <= reg_wdata;
			end
		end
	end

	// Per channel configuration and critical limit, offsets follow the channel index.
	for (genvar i = 0; i < CHANNELS; i++) begin : g_chan_regs
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				temp_config_reg[i]    <= RST_TEMP_CONFIG;
				critical_limit_reg[i] <= RST_CRITICAL_LIMIT;
			end else if (reg_wr) begin
				if (reg_addr == OFS_REMOTE1_TEMP_CONFIG + 8'(i)) begin
					temp_config_reg[i] <= reg_wdata;
				end
				if (reg_addr == OFS_REMOTE1_CRITICAL_LIMIT + 8'(i)) begin // [R10]
					critical_limit_reg[i] <= reg_wdata;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register reads: data lands one cycle after the read strobe.
	assign timer_clear  = reg_rd && (reg_addr == OFS_OVERHEAT_TIMER);
	assign status_clear = reg_rd && (reg_addr == OFS_STATUS_2);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata_reg <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFS_REMOTE1_TEMP_CONFIG:    reg_rdata_reg <= temp_config_reg[0];
				OFS_LOCAL_TEMP_CONFIG:      reg_rdata_reg <= temp_config_reg[1];
				OFS_REMOTE2_TEMP_CONFIG:    reg_rdata_reg <= temp_config_reg[2];
				OFS_ACOUSTICS_CONTROL_1:    reg_rdata_reg <= acoustics_control_1_reg;
				OFS_REMOTE1_CRITICAL_LIMIT: reg_rdata_reg <= critical_limit_reg[0];
				OFS_LOCAL_CRITICAL_LIMIT:   reg_rdata_reg <= critical_limit_reg[1];
				OFS_REMOTE2_CRITICAL_LIMIT: reg_rdata_reg <= critical_limit_reg[2];
				OFS_ALERT_MASK_2:           reg_rdata_reg <= alert_mask_2_reg;
				OFS_CONFIG_3:               reg_rdata_reg <= config_3_reg;
				OFS_OVERHEAT_TIMER:         reg_rdata_reg <= timer_value;
				OFS_OVERHEAT_LIMIT:         reg_rdata_reg <= overheat_limit_reg;
				OFS_STATUS_2:
					reg_rdata_reg <= 8'(overheat_limit_flag_reg) << BIT_LIMIT_FLAG;
				default:                    reg_rdata_reg <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin input. Only the second stage is read by any logic.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			line_meta_reg <= 1'b1;
			line_sync_reg <= 1'b1;
		end else begin
			line_meta_reg <= overheat_line_in; // [R17]
			line_sync_reg <= line_meta_reg;
		end
	end

	// The synchroniser lags the pin by two edges, so our own release would otherwise read as an
	// external assertion for two cycles; the pull-down history covers that lag.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			drive_low_hist_reg <= 2'h0;
		end else begin
			drive_low_hist_reg <= {drive_low_hist_reg[0], drive_low_reg}; // [R17]
		end
	end

	// Our own pull-down is not counted, otherwise the output would feed the timer and full_speed_on_alarm.
	assign line_asserted = !line_sync_reg && !drive_low_reg && (drive_low_hist_reg == 2'h0);
	assign timer_run     = line_asserted && config_3_reg[BIT_MONITOR_ENABLE]; // [R1]

	ohpc_timer #(
		.UNIT_CYCLES (UNIT_CYCLES)
	) u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.run   (timer_run),
		.clear (timer_clear),
		.value (timer_value)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Limit flag. A zero limit trips as soon as the first-assertion bit shows.
	assign limit_hit = timer_value > overheat_limit_reg; // [R5] [R6]

	// A new hit in the same cycle as the clearing read wins.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			overheat_limit_flag_reg <= 1'b0;
		end else if (limit_hit) begin
			overheat_limit_flag_reg <= 1'b1; // [R15] [R16]
		end else if (status_clear) begin
			overheat_limit_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			smbalert_n_reg <= 1'b1;
		end else begin
			smbalert_n_reg <= !(overheat_limit_flag_reg && !alert_mask_2_reg[BIT_LIMIT_MASK]); // [R4]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fan full_speed_on_alarm on an asserted input.
	assign full_speed_on_alarm_active = timer_run && config_3_reg[BIT_FULL_SPEED]; // [R2] [R3]

	for (genvar i = 0; i < CHANNELS; i++) begin : g_fan
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				fan_drive_reg[i] <= ZERO_DUTY;
			end else if (full_speed_on_alarm_active && fan_running[i]) begin
				fan_drive_reg[i] <= FULL_DUTY; // [R2] [R14]
			end else begin
				fan_drive_reg[i] <= duty_in[i]; // [R3]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin output. Each channel keeps its trip from its latest measurement.
	for (genvar i = 0; i < CHANNELS; i++) begin : g_trip
		assign out_enable[i] = temp_config_reg[i][BIT_OUTPUT_ENABLE]; // [R11]
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				trip_reg[i] <= 1'b0;
			end else if (temp_valid[i]) begin
				// Quarter degree resolution: above the limit is at least a quarter over it.
				trip_reg[i] <= temp_in[i] > {critical_limit_reg[i], 2'b00}; // [R7] [R10]
			end
		end
	end

	// Deciding only at the cycle boundary holds the pin for a whole cycle.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			drive_low_reg <= 1'b0;
		end else if (monitor_cycle_done) begin
			drive_low_reg <= |(trip_reg & out_enable); // [R8] [R9] [R11]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Speed input to drive channel association.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			speed_gate_reg <= 4'h0;
		end else if (acoustics_control_1_reg[BIT_GANG_SELECT]) begin
			speed_gate_reg <= {drive_pwm[1], drive_pwm[1], drive_pwm[1], drive_pwm[0]}; // [R13]
		end else begin
			speed_gate_reg <= {drive_pwm[2], drive_pwm[2], drive_pwm[1], drive_pwm[0]}; // [R12]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign reg_rdata         = reg_rdata_reg;
	assign overheat_line_out = 1'b0;
	assign overheat_line_oe  = drive_low_reg; // [R17]
	assign smbalert_n        = smbalert_n_reg;
	assign fan_drive_1       = fan_drive_reg[0];
	assign fan_drive_2       = fan_drive_reg[1];
	assign fan_drive_3       = fan_drive_reg[2];
	assign speed_input_gate  = speed_gate_reg;

endmodule : ohpc_top

// >>> ohpc_pkg.sv
// Shared constants for the overheat pin control block.
package ohpc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] OFS_REMOTE1_TEMP_CONFIG    = 8'h5F;
	localparam logic [7:0] OFS_LOCAL_TEMP_CONFIG      = 8'h60;
	localparam logic [7:0] OFS_REMOTE2_TEMP_CONFIG    = 8'h61;
	localparam logic [7:0] OFS_ACOUSTICS_CONTROL_1    = 8'h62;
	localparam logic [7:0] OFS_REMOTE1_CRITICAL_LIMIT = 8'h6A;
	localparam logic [7:0] OFS_LOCAL_CRITICAL_LIMIT   = 8'h6B;
	localparam logic [7:0] OFS_REMOTE2_CRITICAL_LIMIT = 8'h6C;
	localparam logic [7:0] OFS_ALERT_MASK_2           = 8'h75;
	localparam logic [7:0] OFS_CONFIG_3               = 8'h78;
	localparam logic [7:0] OFS_OVERHEAT_TIMER         = 8'h79;
	localparam logic [7:0] OFS_OVERHEAT_LIMIT         = 8'h7A;
	localparam logic [7:0] OFS_STATUS_2               = 8'h42;

	////////////////////////////////////////////////////////////////////////////////
	localparam int BIT_MONITOR_ENABLE     = 1;
	localparam int BIT_FULL_SPEED         = 2;
	localparam int BIT_LIMIT_MASK         = 5;
	localparam int BIT_LIMIT_FLAG         = 5;
	localparam int BIT_OUTPUT_ENABLE      = 3;
	localparam int BIT_GANG_SELECT        = 4;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] RST_TEMP_CONFIG    = 8'h00;
	localparam logic [7:0] RST_ACOUSTICS      = 8'h00;
	localparam logic [7:0] RST_CRITICAL_LIMIT = 8'h64;
	localparam logic [7:0] RST_ALERT_MASK_2   = 8'h00;
	localparam logic [7:0] RST_CONFIG_3       = 8'h00;
	localparam logic [7:0] RST_OVERHEAT_LIMIT = 8'h00;
	localparam logic [7:0] FULL_DUTY          = 8'hFF;
	localparam logic [7:0] ZERO_DUTY          = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	localparam int CLK_PERIOD_NS    = 10;
	localparam int TIMER_UNIT_NS    = 22_760_000;
	localparam int TIMER_UNIT_CYCLES = (TIMER_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : ohpc_pkg

// >>> ohpc_timer.sv
// Cumulative overheat assertion timer with clear on read and saturation.
`timescale 1ns/1ns
module ohpc_timer
	import ohpc_pkg::*;
#(
	parameter int UNIT_CYCLES = TIMER_UNIT_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       run,
	input  wire logic       clear,
	output logic      [7:0] value
);

	logic [31:0] sub_reg;
	logic [7:0]  units_reg;
	logic        seen_reg;
	logic        unit_tick;

	assign unit_tick = run && (sub_reg == 32'(UNIT_CYCLES - 1));

	////////////////////////////////////////////////////////////////////////////////
	// The sub-unit count restarts on clear, so a read loses less than one unit.
	always_ff @(posedge clk) begin
		if (!rst_n || clear || unit_tick) begin
			sub_reg <= 32'h0000_0000;
		end else if (run) begin
			sub_reg <= sub_reg + 32'h0000_0001;
		end
	end

	// Whole units stop at full scale until cleared.
	always_ff @(posedge clk) begin
		if (!rst_n || clear) begin
			units_reg <= 8'h00;
		end else if (unit_tick && units_reg != 8'hFF) begin
			units_reg <= units_reg + 8'h01;
		end
	end

	// A clear during an assertion leaves the first-assertion bit set.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			seen_reg <= 1'b0;
		end else if (run) begin
			seen_reg <= 1'b1;
		end else if (clear) begin
			seen_reg <= 1'b0;
		end
	end

	// Below two units only the first-assertion bit shows.
	assign value = (units_reg >= 8'h02) ? units_reg : {7'h00, seen_reg};

endmodule : ohpc_timer

// >>> ohpc_chk.sv
// Concurrent checker for the overheat pin control block.
`timescale 1ns/1ns
module ohpc_chk
	import ohpc_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       overheat_line_in,
	input wire logic       overheat_line_out,
	input wire logic       overheat_line_oe,
	input wire logic       smbalert_n,
	input wire logic       monitor_cycle_done,
	input wire logic [7:0] duty_1,
	input wire logic [2:0] fan_running,
	input wire logic [7:0] fan_drive_1,
	input wire logic [2:0] drive_pwm,
	input wire logic [3:0] speed_input_gate
);
	////////////////////////////////////////////////////////////////////////////////
	// Shadow copies of the control bits, rebuilt from the write strobes alone.
	logic [7:0] cfg_reg, mask_reg, lim_reg, ac_reg;
	logic [2:0] en_reg;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{cfg_reg, mask_reg, lim_reg, ac_reg} <= 32'h0;
			en_reg <= 3'h0;
		end else if (reg_wr) begin
			if (reg_addr == OFS_CONFIG_3) cfg_reg <= reg_wdata;
			if (reg_addr == OFS_ALERT_MASK_2) mask_reg <= reg_wdata;
			if (reg_addr == OFS_OVERHEAT_LIMIT) lim_reg <= reg_wdata;
			if (reg_addr == OFS_ACOUSTICS_CONTROL_1) ac_reg <= reg_wdata;
			if (reg_addr == OFS_REMOTE1_TEMP_CONFIG) en_reg[0] <= reg_wdata[3];
			if (reg_addr == OFS_LOCAL_TEMP_CONFIG) en_reg[1] <= reg_wdata[3];
			if (reg_addr == OFS_REMOTE2_TEMP_CONFIG) en_reg[2] <= reg_wdata[3];
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_out_low_only: assert property (overheat_line_out == 1'h0)
		else $error("pin output level not low");
	a_oe_hold: assert property (!monitor_cycle_done |=> $stable(overheat_line_oe))
		else $error("pin enable moved between cycle ends");
	a_oe_enable: assert property (monitor_cycle_done && en_reg == 3'h0 |=> !overheat_line_oe)
		else $error("pin pulled with no channel enabled");
	a_full_speed_on_alarm_full: assert property ((!overheat_line_in && cfg_reg[2:1] == 2'h3 && fan_running[0]
		&& !overheat_line_oe) [*4] |-> fan_drive_1 == FULL_DUTY)
		else $error("fan drive not at full duty");
	a_full_speed_on_alarm_none: assert property ($past(rst_n) && !(cfg_reg[2] && fan_running[0])
		&& !$past(cfg_reg[2] && fan_running[0]) |-> fan_drive_1 == $past(duty_1))
		else $error("fan drive differs from programmed duty");
	a_map_default: assert property ($past(rst_n) && !ac_reg[4] && !$past(ac_reg[4]) |->
		speed_input_gate == {{2{$past(drive_pwm[2])}}, $past(drive_pwm[1:0])})
		else $error("default speed input mapping wrong");
	a_map_gang: assert property ($past(rst_n) && ac_reg[4] && $past(ac_reg[4]) |->
		speed_input_gate == {{3{$past(drive_pwm[1])}}, $past(drive_pwm[0])})
		else $error("ganged speed input mapping wrong");
	a_alert_masked: assert property (mask_reg[5] && $past(mask_reg[5]) |-> smbalert_n)
		else $error("alert raised while masked");
	a_limit_zero: assert property (cfg_reg[1] && lim_reg == 8'h00 && !mask_reg[5]
		&& !overheat_line_oe && $fell(overheat_line_in) |-> ##[1:8] !smbalert_n)
		else $error("no alert on first assertion");
	c_full_speed_on_alarm: cover property (fan_drive_1 == FULL_DUTY);
	c_alert: cover property (!smbalert_n);
	c_pin_out: cover property ($rose(overheat_line_oe));
endmodule : ohpc_chk

bind ohpc_top ohpc_chk u_chk (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .overheat_line_in,
	.overheat_line_out, .overheat_line_oe, .smbalert_n, .monitor_cycle_done, .duty_1,
	.fan_running, .fan_drive_1, .drive_pwm, .speed_input_gate);

// >>> ohpc_pin_src.sv
// Far-side source that shares the open-drain overheat line with the block.
`timescale 1ns/1ns
module ohpc_pin_src (
	input  wire logic pull_req,
	input  wire logic dut_oe,
	output logic      line
);
	////////////////////////////////////////////////////////////////////////////////
	// Either party may only pull low; the board pull-up makes a released line read high.
	assign line = !(pull_req || dut_oe);
endmodule : ohpc_pin_src

// >>> ohpc_top_tb.sv
// Self-checking testbench for the overheat pin control block.
`timescale 1ns/1ns
module ohpc_top_tb
	import ohpc_pkg::*;
;
	logic       clk, rst_n, reg_wr, reg_rd, mcd, pull_req, line, oe, out, alert_n;
	logic [7:0] addr, wdata, rdata, d1, d2, d3, f1, f2, f3;
	logic [9:0] t1, t2, t3;
	logic [2:0] tv, run, pwm;
	logic [3:0] gate, eg;
	int         err_count, check_count;
	logic [7:0] ra [10] = '{8'h5F, 8'h60, 8'h61, 8'h62, 8'h6A, 8'h6B, 8'h6C, 8'h75, 8'h78, 8'h00};
	logic [7:0] rv [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h64, 8'h64, 8'h64, 8'h00, 8'h00, 8'h00};
	ohpc_top #(.UNIT_CYCLES(8), .CHANNELS(3)) uut (.clk(clk), .rst_n(rst_n), .reg_addr(addr),
		.reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
		.overheat_line_in(line), .overheat_line_out(out), .overheat_line_oe(oe),
		.smbalert_n(alert_n), .temp_remote1(t1), .temp_local(t2), .temp_remote2(t3),
		.temp_valid(tv), .monitor_cycle_done(mcd), .duty_1(d1), .duty_2(d2), .duty_3(d3),
		.fan_running(run), .fan_drive_1(f1), .fan_drive_2(f2), .fan_drive_3(f3),
		.drive_pwm(pwm), .speed_input_gate(gate));
	ohpc_pin_src u_src (.pull_req(pull_req), .dut_oe(oe), .line(line));
	////////////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic chk1(input string nm, input logic e, input logic g);
		chk(nm, {7'h0, e}, {7'h0, g});
	endtask : chk1
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	// Strobes drop for a cycle between calls so back-to-back calls never collide.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		reg_wr = 1'h1;
		cyc(1);
		reg_wr = 1'h0;
		cyc(1);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, string nm);
		addr = a;
		reg_rd = 1'h1;
		cyc(1);
		reg_rd = 1'h0;
		chk(nm, e, rdata & m);
		cyc(1);
	endtask : rd
	task automatic mc(input logic [9:0] r1, input logic [9:0] l, input logic [9:0] r2);
		{t1, t2, t3} = {r1, l, r2};
		tv = 3'h7;
		cyc(1);
		tv = 3'h0;
		mcd = 1'h1;
		cyc(1);
		mcd = 1'h0;
		cyc(1);
	endtask : mc
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	initial begin
		#1_000_000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		{rst_n, reg_wr, reg_rd, mcd, pull_req, addr, wdata, t1, t2, t3, tv, pwm} = 0;
		{d1, d2, d3, run} = {8'h33, 8'h44, 8'h55, 3'h3};
		err_count = 0;
		check_count = 0;
		cyc(3);
		rst_n = 1'h1;
		foreach (ra[i]) rd(ra[i], 8'hFF, rv[i], "reset value");
		foreach (ra[i]) begin
			wr(ra[i], 8'hA5 ^ 8'(i));
			rd(ra[i], 8'hFF, (ra[i] == 8'h00) ? 8'h00 : (8'hA5 ^ 8'(i)), "readback");
			wr(ra[i], rv[i]);
		end
		// Pin activity with monitoring off must leave timer and flag untouched.
		pull_req = 1'h1;
		cyc(40);
		pull_req = 1'h0;
		cyc(3);
		rd(8'h79, 8'hFF, 8'h00, "timer off");
		rd(8'h42, 8'h20, 8'h00, "flag off");
		wr(8'h78, 8'h02);
		pull_req = 1'h1;
		cyc(8);
		chk1("alert first", 1'h0, alert_n);
		wr(8'h75, 8'h20);
		cyc(1);
		chk1("alert masked", 1'h1, alert_n);
		rd(8'h42, 8'h20, 8'h20, "flag masked");
		pull_req = 1'h0;
		cyc(3);
		rd(8'h79, 8'hFF, 8'h01, "timer first");
		rd(8'h42, 8'h20, 8'h20, "flag before clear");
		rd(8'h42, 8'h20, 8'h00, "flag cleared");
		wr(8'h75, 8'h00);
		wr(8'h7A, 8'h01);
		cyc(1);
		chk1("alert cleared", 1'h1, alert_n);
		// Two separate assertions accumulate past the limit of one unit.
		for (int k = 0; k < 2; k++) begin
			pull_req = 1'h1;
			cyc(10);
			pull_req = 1'h0;
			cyc(4);
			chk1("alert limit", k[0] ? 1'h0 : 1'h1, alert_n);
		end
		rd(8'h79, 8'hFF, 8'h02, "timer sum");
		wr(8'h78, 8'h06);
		pull_req = 1'h1;
		cyc(5);
		chk("drive 1", FULL_DUTY, f1);
		chk("drive 2", FULL_DUTY, f2);
		chk("drive 3", d3, f3);
		wr(8'h78, 8'h02);
		chk("drive 1", d1, f1);
		pull_req = 1'h0;
		wr(8'h78, 8'h00);
		wr(8'h6A, 8'h50);
		wr(8'h6C, 8'h20);
		mc(10'h141, 10'h191, 10'h000);
		chk1("pin idle", 1'h0, oe);
		wr(8'h60, 8'h08);
		mc(10'h141, 10'h190, 10'h000);
		chk1("pin at limit", 1'h1, line);
		mc(10'h000, 10'h191, 10'h000);
		chk1("pin low", 1'h0, line);
		t2 = 10'h000;
		tv = 3'h7;
		cyc(1);
		tv = 3'h0;
		cyc(3);
		chk1("pin held", 1'h1, oe);
		mc(10'h000, 10'h000, 10'h000);
		chk1("pin freed", 1'h0, oe);
		wr(8'h61, 8'h08);
		mc(10'h000, 10'h000, 10'h081);
		chk1("remote 2", 1'h1, oe);
		mc(10'h000, 10'h000, 10'h080);
		chk1("remote 2 limit", 1'h0, oe);
		for (int g = 0; g < 2; g++) begin
			wr(8'h62, g[0] ? 8'h10 : 8'h00);
			for (int i = 0; i < 8; i++) begin
				pwm = 3'(i);
				cyc(1);
				eg = g[0] ? {{3{pwm[1]}}, pwm[0]} : {{2{pwm[2]}}, pwm[1:0]};
				chk("speed gate", {4'h0, eg}, {4'h0, gate});
			end
		end
		tally_and_finish();
	end
endmodule : ohpc_top_tb
